// ---- pcc_pkg.sv ----
// Purpose: Shared constants and carriers for the performance counter control block
// Assumes: 64-bit state register access from the core pipeline
// Notes: Register numbers are state register indices, not byte addresses
package pcc_pkg;
	localparam logic [4:0] REG_PERF_CONTROL = 5'h10;
	localparam logic [4:0] REG_PERF_COUNTER_WINDOW = 5'h11;
	localparam int NUM_PAIRS = 4;
	localparam int CNT_W = 32;
	localparam int STATUS_LO = 32;
	localparam int STATUS_HI = 47;
	localparam int STATUS_INHIBIT_BIT = 26;
	localparam int PAIRS_LO = 22;
	localparam int PAIRS_HI = 24;
	localparam int SEL_LO = 18;
	localparam int SEL_HI = 20;
	localparam int UEV_LO = 11;
	localparam int UEV_HI = 16;
	localparam int LEV_LO = 4;
	localparam int LEV_HI = 9;
	localparam int EV_INHIBIT_BIT = 3;
	localparam int USER_EN_BIT = 2;
	localparam int SYS_EN_BIT = 1;
	localparam int RESTRICT_BIT = 0;
	localparam logic [2:0] PAIR_COUNT_CODE = 3'h3;
	localparam int SOFT_INT_BIT = 15;
	localparam logic [3:0] OVERFLOW_IRQ_LEVEL = 4'hf;
	localparam logic [5:0] EV_SEL_RESET = 6'h00;
	localparam logic [2:0] SEL_RESET = 3'h0;

	// One register access from the pipeline
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] regnum;
		logic [63:0] wdata;
	} pcc_req_t;

	// Answer to one access
	typedef struct packed {
		logic valid;
		logic access_fault;
		logic [63:0] rdata;
	} pcc_rsp_t;
endpackage : pcc_pkg

// ---- pcc_perf_counter_control.sv ----
// Purpose: Performance control and counter window registers with overflow tracking
// Assumes: Event strobes are one per cycle per event line, synchronous to sys_clk
// Notes: Answer to each access arrives one cycle after the request
`timescale 1ns/1ps
module pcc_perf_counter_control #(
	parameter int NUM_EVENTS = 64
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire pcc_pkg::pcc_req_t req,
	input wire logic thread_privileged,
	input wire logic [NUM_EVENTS-1:0] event_strobe,
	output pcc_pkg::pcc_rsp_t rsp,
	output logic soft_interrupt_set,
	output logic irq_valid,
	output logic [3:0] irq_level,
	output logic access_restrict
);
	localparam int NP = pcc_pkg::NUM_PAIRS;

	logic [pcc_pkg::CNT_W-1:0] upper_counter [NP];
	logic [pcc_pkg::CNT_W-1:0] lower_counter [NP];
	logic [5:0] upper_event_select [NP];
	logic [5:0] lower_event_select [NP];
	logic [2:0] pair_select;
	logic user_count_enable;
	logic system_count_enable;
	logic [15:0] overflow_status;
	logic [15:0] next_overflow_status;
	logic [15:0] hw_overflow;
	logic [63:0] next_rdata;
	logic [1:0] psel;
	logic [1:0] wsel;
	logic ctl_hit;
	logic win_hit;
	logic set_restrict;
	logic ctl_fault;
	logic ctl_wr;
	logic ctl_rd;
	logic win_wr;
	logic win_rd;
	logic count_on;
	logic keep_status;
	logic keep_selects;

	// Only four pairs exist; upper select codes alias onto them
	assign psel = pair_select[1:0];
	// Event selects follow the pair named by the write itself, not the stored one
	assign wsel = req.wdata[pcc_pkg::SEL_LO+1:pcc_pkg::SEL_LO];

	// Codes at or beyond the event count select nothing
	function automatic logic event_hit(input logic [NUM_EVENTS-1:0] ev, input logic [5:0] sel);
		event_hit = (32'(sel) < NUM_EVENTS) ? ev[sel] : 1'h0;
	endfunction : event_hit

	// A window write lands on pair idx this cycle
	function automatic logic pair_taken(input logic wr, input logic [1:0] sel, input int idx);
		pair_taken = wr && sel == 2'(idx);
	endfunction : pair_taken

	// Read image of the control register; inhibit and reserved bits read zero
	function automatic logic [63:0] control_image(
		input logic [15:0] status,
		input logic [2:0] sel,
		input logic [5:0] up_sel,
		input logic [5:0] lo_sel,
		input logic user_en,
		input logic sys_en,
		input logic restrict_bit
	);
		logic [63:0] word;
		word = '0;
		word[pcc_pkg::STATUS_HI:pcc_pkg::STATUS_LO] = status;
		word[pcc_pkg::PAIRS_HI:pcc_pkg::PAIRS_LO] = pcc_pkg::PAIR_COUNT_CODE;
		word[pcc_pkg::SEL_HI:pcc_pkg::SEL_LO] = sel;
		word[pcc_pkg::UEV_HI:pcc_pkg::UEV_LO] = up_sel;
		word[pcc_pkg::LEV_HI:pcc_pkg::LEV_LO] = lo_sel;
		word[pcc_pkg::USER_EN_BIT] = user_en;
		word[pcc_pkg::SYS_EN_BIT] = sys_en;
		word[pcc_pkg::RESTRICT_BIT] = restrict_bit;
		control_image = word;
	endfunction : control_image

	// Access decode
	assign ctl_hit = req.valid && req.regnum == pcc_pkg::REG_PERF_CONTROL;
	assign win_hit = req.valid && req.regnum == pcc_pkg::REG_PERF_COUNTER_WINDOW;
	assign set_restrict = req.wdata[pcc_pkg::RESTRICT_BIT];
	// A faulting access leaves every register as it was
	assign ctl_fault = ctl_hit && !thread_privileged &&
		(access_restrict || (req.write && set_restrict));
	assign ctl_wr = ctl_hit && req.write && !ctl_fault;
	assign ctl_rd = ctl_hit && !req.write && !ctl_fault;
	assign win_wr = win_hit && req.write;
	assign win_rd = win_hit && !req.write;
	assign keep_status = req.wdata[pcc_pkg::STATUS_INHIBIT_BIT];
	assign keep_selects = req.wdata[pcc_pkg::EV_INHIBIT_BIT];
	assign count_on = thread_privileged ? system_count_enable : user_count_enable;

	// Counters: software write to the window pair wins over counting
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NP; i++) begin
			if (sys_rst) begin
				upper_counter[i] <= '0;
				lower_counter[i] <= '0;
			end else if (pair_taken(win_wr, psel, i)) begin
				upper_counter[i] <= req.wdata[63:32];
				lower_counter[i] <= req.wdata[31:0];
			end else if (count_on) begin
				// All-ones plus one wraps to zero with no extra logic
				if (event_hit(event_strobe, upper_event_select[i]))
					upper_counter[i] <= upper_counter[i] + 32'h1;
				if (event_hit(event_strobe, lower_event_select[i]))
					lower_counter[i] <= lower_counter[i] + 32'h1;
			end
		end
	end

	// Status bit 2i is lower counter i, bit 2i+1 is upper counter i
	always_comb begin
		hw_overflow = '0;
		for (int i = 0; i < NP; i++) begin
			hw_overflow[2*i] = !pair_taken(win_wr, psel, i) && count_on &&
				event_hit(event_strobe, lower_event_select[i]) &&
				(&lower_counter[i]);
			hw_overflow[2*i+1] = !pair_taken(win_wr, psel, i) && count_on &&
				event_hit(event_strobe, upper_event_select[i]) &&
				(&upper_counter[i]);
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_comb begin
		if (ctl_wr && !keep_status)
			next_overflow_status = req.wdata[pcc_pkg::STATUS_HI:pcc_pkg::STATUS_LO] |
				hw_overflow;
		else
			next_overflow_status = overflow_status | hw_overflow;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			overflow_status <= '0;
		else
			overflow_status <= next_overflow_status;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pair_select <= pcc_pkg::SEL_RESET;
			user_count_enable <= 1'h0;
			system_count_enable <= 1'h0;
			access_restrict <= 1'h0;
		end else if (ctl_wr) begin
			pair_select <= req.wdata[pcc_pkg::SEL_HI:pcc_pkg::SEL_LO];
			user_count_enable <= req.wdata[pcc_pkg::USER_EN_BIT];
			system_count_enable <= req.wdata[pcc_pkg::SYS_EN_BIT];
			access_restrict <= set_restrict;
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NP; i++) begin
			if (sys_rst) begin
				upper_event_select[i] <= pcc_pkg::EV_SEL_RESET;
				lower_event_select[i] <= pcc_pkg::EV_SEL_RESET;
			end else if (ctl_wr && !keep_selects && wsel == 2'(i)) begin
				upper_event_select[i] <= req.wdata[pcc_pkg::UEV_HI:pcc_pkg::UEV_LO];
				lower_event_select[i] <= req.wdata[pcc_pkg::LEV_HI:pcc_pkg::LEV_LO];
			end
		end
	end

	// Read data is taken before this cycle's update takes effect
	always_comb begin
		next_rdata = '0;
		if (ctl_rd)
			next_rdata = control_image(overflow_status, pair_select,
				upper_event_select[psel], lower_event_select[psel],
				user_count_enable, system_count_enable, access_restrict);
		else if (win_rd)
			next_rdata = {upper_counter[psel], lower_counter[psel]};
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.access_fault <= ctl_fault;
			rsp.rdata <= next_rdata;
		end
	end

	// Only hardware overflow raises the interrupt; software sets do not
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			soft_interrupt_set <= 1'h0;
		else
			soft_interrupt_set <= |hw_overflow;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_valid <= 1'h0;
			irq_level <= 4'h0;
		end else begin
			irq_valid <= |hw_overflow;
			irq_level <= pcc_pkg::OVERFLOW_IRQ_LEVEL;
		end
	end
endmodule : pcc_perf_counter_control

// ---- pcc_pipe_model.sv ----
// Purpose: Pipeline stand-in issuing state register accesses
// Assumes: One access in flight, answer one cycle after it is taken
// Notes: Released request lines show inverted data, never the last value
`timescale 1ns/1ps
module pcc_pipe_model (
	input wire logic sys_clk,
	input wire pcc_pkg::pcc_rsp_t rsp,
	output pcc_pkg::pcc_req_t req
);
	initial req = '0;
	task automatic access(input logic w, input logic [4:0] r, input logic [63:0] d,
		output pcc_pkg::pcc_rsp_t q);
		@(posedge sys_clk) #1 req = {1'h1, w, r, d};
		@(posedge sys_clk) #1 req = {2'h0, ~r, ~d};
		q = rsp;
	endtask : access
endmodule : pcc_pipe_model

// ---- pcc_perf_counter_control_monitor.sv ----
// Purpose: Port checks of faults, answers and overflow interrupts
// Assumes: One clock, synchronous active-high reset
// Notes: Counter values are judged by the bench
`timescale 1ns/1ps
module pcc_perf_counter_control_monitor #(parameter int NUM_EVENTS = 64) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire pcc_pkg::pcc_req_t req,
	input wire logic thread_privileged,
	input wire logic [NUM_EVENTS-1:0] event_strobe,
	input wire pcc_pkg::pcc_rsp_t rsp,
	input wire logic soft_interrupt_set,
	input wire logic irq_valid,
	input wire logic [3:0] irq_level,
	input wire logic access_restrict
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire ctl = req.valid && req.regnum == 5'h10;
	sequence s_user;
		ctl && !thread_privileged;
	endsequence
	a_restrict_fault: assert property (s_user ##0 access_restrict |=> rsp.access_fault)
		else $error("restricted access passed");
	a_restrict_set: assert property (s_user ##0 (req.write && req.wdata[0]) |=> rsp.access_fault)
		else $error("restrict set passed");
	a_user_read: assert property (s_user ##0 (!access_restrict && !req.write) |=> !rsp.access_fault)
		else $error("user read refused");
	a_answer_next: assert property (req.valid |=> rsp.valid)
		else $error("answer missing");
	a_window_free: assert property (req.valid && req.regnum == 5'h11 |=> !rsp.access_fault)
		else $error("window refused");
	a_read_fields: assert property (ctl && !req.write && thread_privileged |=>
		rsp.rdata[26] == 1'h0 && rsp.rdata[3] == 1'h0 && rsp.rdata[24:22] == 3'h3)
		else $error("fixed fields wrong");
	a_irq_level: assert property (irq_valid |-> irq_level == 4'hf && soft_interrupt_set)
		else $error("irq level wrong");
	a_restrict_kept: assert property ($changed(access_restrict) |->
		$past(ctl && req.write) && !rsp.access_fault)
		else $error("restrict changed alone");
endmodule : pcc_perf_counter_control_monitor

// ---- pcc_testbench.sv ----
// Purpose: Self-checking bench for the performance counter control block
// Assumes: Pipeline model issues accesses, events driven here
// Notes: Overflow is forced by loading the window near all-ones
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic thread_privileged = 1'h1;
	logic [63:0] event_strobe = 64'h0;
	pcc_pkg::pcc_req_t req;
	pcc_pkg::pcc_rsp_t rsp, q;
	logic soft_interrupt_set, irq_valid, access_restrict;
	logic [3:0] irq_level;
	int num_errors = 0;
	int n_compared = 0;
	always #2.5 sys_clk = ~sys_clk;
	pcc_perf_counter_control pcc_perf_counter_control_inst (.*);
	pcc_pipe_model pcc_pipe_model_inst (.*);
	function automatic logic [63:0] ctl(input logic [15:0] o, input logic [2:0] s,
		input logic [5:0] u, input logic [5:0] l);
		return {16'h0, o, 7'h0, 3'h3, 1'h0, s, 1'h0, u, 1'h0, l, 4'h2};
	endfunction : ctl
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] r, input logic [63:0] d);
		pcc_pipe_model_inst.access(w, r, d, q);
		chk(q.valid, 1'h1);
	endtask : acc
	task automatic pulse(input logic [63:0] m);
		@(posedge sys_clk) #1 event_strobe = m;
		@(posedge sys_clk) #1 event_strobe = 64'h0;
	endtask : pulse
	task automatic t_select;
		acc(1'h1, 5'h10, ctl(16'h0, 3'h1, 6'h2, 6'h1));
		acc(1'h1, 5'h10, ctl(16'h0, 3'h0, 6'h5, 6'h5) | 64'h8);
		acc(1'h0, 5'h10, 64'h0);
		chk(q.rdata, ctl(16'h0, 3'h0, 6'h0, 6'h0));
		acc(1'h1, 5'h10, ctl(16'h0, 3'h1, 6'h0, 6'h0) | 64'h8);
		acc(1'h0, 5'h10, 64'h0);
		chk(q.rdata, ctl(16'h0, 3'h1, 6'h2, 6'h1));
	endtask : t_select
	task automatic t_overflow;
		acc(1'h1, 5'h11, 64'hffffffff_fffffffe);
		pulse(64'h4);
		chk({soft_interrupt_set, irq_valid}, 2'h3);
		pulse(64'h2);
		chk(irq_valid, 1'h0);
		acc(1'h0, 5'h11, 64'h0);
		chk(q.rdata, 64'hffffffff);
		acc(1'h1, 5'h10, ctl(16'h0, 3'h1, 6'h2, 6'h1) | 64'h4000000);
		acc(1'h0, 5'h10, 64'h0);
		chk(q.rdata, ctl(16'h8, 3'h1, 6'h2, 6'h1));
		acc(1'h1, 5'h10, ctl(16'h1, 3'h1, 6'h2, 6'h1));
		chk(irq_valid, 1'h0);
		acc(1'h0, 5'h10, 64'h0);
		chk(q.rdata, ctl(16'h1, 3'h1, 6'h2, 6'h1));
		acc(1'h1, 5'h11, 64'hffffffff_ffffffff);
		pulse(64'h6);
		chk({soft_interrupt_set, irq_valid}, 2'h3);
		acc(1'h0, 5'h10, 64'h0);
		chk(q.rdata, ctl(16'hd, 3'h1, 6'h2, 6'h1));
		acc(1'h0, 5'h11, 64'h0);
		chk(q.rdata, 64'h0);
	endtask : t_overflow
	task automatic t_access_restrict;
		thread_privileged = 1'h0;
		acc(1'h0, 5'h10, 64'h0);
		chk(q.access_fault, 1'h0);
		acc(1'h1, 5'h10, 64'h1);
		chk(q.access_fault, 1'h1);
		acc(1'h1, 5'h05, 64'h1);
		chk({q.access_fault, q.rdata[62:0]}, 64'h0);
		thread_privileged = 1'h1;
		acc(1'h1, 5'h10, 64'h1);
		chk(access_restrict, 1'h1);
		thread_privileged = 1'h0;
		acc(1'h0, 5'h10, 64'h0);
		chk(q.access_fault, 1'h1);
		acc(1'h0, 5'h11, 64'h0);
		chk(q.access_fault, 1'h0);
		thread_privileged = 1'h1;
		acc(1'h1, 5'h10, 64'h4);
		acc(1'h1, 5'h11, 64'h0);
		pulse(64'h1);
		thread_privileged = 1'h0;
		pulse(64'h1);
		acc(1'h0, 5'h11, 64'h0);
		chk(q.rdata, 64'h00000001_00000001);
	endtask : t_access_restrict
	task automatic summarize;
		if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(posedge sys_clk);
		#1 sys_rst = 1'h0;
		t_select();
		t_overflow();
		t_access_restrict();
		summarize();
	end
	// Watchdog so a stuck access still reaches the verdict
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
endmodule : testbench
bind pcc_perf_counter_control pcc_perf_counter_control_monitor #(.NUM_EVENTS(NUM_EVENTS))
	pcc_perf_counter_control_monitor_inst (.*);
